//--- design/pbcfg_host.sv
// pbcfg_host: host-side sequencer that programs a bridge configuration header
// assumes a simple config access port: one request, one done pulse per access
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Function
// - write zeros to both upper prefetchable address halves
// - write zeros to upper I/O base and limit halves
// - b2b_capable_property enable set only if all secondary devices capable
// - keep secondary bus reset control at zero
// - write master abort mode control as zero
// - write VGA enable as zero so legacy VGA is not forwarded
// - write ISA enable as one, blocking top 768 bytes per 1K
// - write system-error enable and parity response as zero
// - read interrupt pin, record nonzero value, no further meaning
// - interrupt line register left unwritten and unused
// - expansion ROM base register left untouched
// - no memory behind bridge means base programmed above limit
module pbcfg_host
   import pbcfg_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        rstn_i,
   // software register port
   input  wire logic [3:0]  sw_addr_i,
   input  wire logic [31:0] sw_wdata_i,
   input  wire logic        sw_wr_i,
   input  wire logic        sw_rd_i,
   output logic      [31:0] sw_rdata_o,
   // configuration access port toward the bridge
   output logic             cfg_req_o,
   output logic             cfg_we_o,
   output logic      [7:0]  cfg_off_o,
   output logic      [31:0] cfg_wdata_o,
   output logic      [3:0]  cfg_be_o,
   input  wire logic [31:0] cfg_rdata_i,
   input  wire logic        cfg_done_i
);
   // ****************************************
   // state
   // ****************************************
   typedef enum {
      S_IDLE, S_PF_BL, S_PF_BU, S_PF_LU, S_IO_UP, S_MEM_BL, S_IO_BL,
      S_PIN_RD, S_BRCTL, S_DONE
   } pbcfg_state_type;

   pbcfg_state_type state_q, state_d;
   logic        busy_q, busy_d;
   logic        done_q, done_d;
   logic        b2b_q, b2b_d;
   logic        mem_need_q, mem_need_d;
   logic [31:0] mem_win_q, mem_win_d;
   logic [31:0] io_win_q, io_win_d;
   logic [7:0]  irq_pin_q, irq_pin_d;
   logic        pin_valid_q, pin_valid_d;
   logic        req_q, req_d;
   logic        we_q, we_d;
   logic [7:0]  off_q, off_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0]  be_q, be_d;
   logic [31:0] rdata_q, rdata_d;
   logic        done_sync1_q, done_sync2_q;
   logic [31:0] cfg_rdata_s1_q, cfg_rdata_s2_q;

   // ****************************************
   // input synchronisers
   // ****************************************
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         done_sync1_q   <= 1'b0;
         done_sync2_q   <= 1'b0;
         cfg_rdata_s1_q <= 32'h0000_0000;
         cfg_rdata_s2_q <= 32'h0000_0000;
      end else begin
         done_sync1_q   <= cfg_done_i;
         done_sync2_q   <= done_sync1_q;
         cfg_rdata_s1_q <= cfg_rdata_i;
         cfg_rdata_s2_q <= cfg_rdata_s1_q;
      end
   end

   logic start_w;
   assign start_w = sw_wr_i && (sw_addr_i == REG_CTRL_OFF) && sw_wdata_i[0];

   logic [7:0]  pin_field_w;
   assign pin_field_w = cfg_rdata_s2_q[IRQ_PIN_LSB +: 8];

   // ****************************************
   // sequencer next state
   // ****************************************
   always_comb begin
      logic [7:0] brctl_low;
      brctl_low   = b2b_q ? BRCTL_LOW_ISA_B2B : BRCTL_LOW_ISA_ONLY;
      state_d     = state_q;
      busy_d      = busy_q;
      done_d      = done_q;
      b2b_d       = b2b_q;
      mem_need_d  = mem_need_q;
      mem_win_d   = mem_win_q;
      io_win_d    = io_win_q;
      irq_pin_d   = irq_pin_q;
      pin_valid_d = pin_valid_q;
      req_d       = 1'b0;
      we_d        = we_q;
      off_d       = off_q;
      wdata_d     = wdata_q;
      be_d        = be_q;
      if (sw_wr_i && !busy_q) begin
         if (sw_addr_i == REG_CTRL_OFF) begin
            b2b_d      = sw_wdata_i[1];
            mem_need_d = sw_wdata_i[2];
         end else if (sw_addr_i == REG_MEM_WIN_OFF) begin
            mem_win_d = sw_wdata_i;
         end else if (sw_addr_i == REG_IO_WIN_OFF) begin
            io_win_d = sw_wdata_i;
         end
      end
      case (state_q)
         S_IDLE: begin
            if (start_w) begin
               state_d = S_PF_BL;
               busy_d  = 1'b1;
               done_d  = 1'b0;
               req_d   = 1'b1;
               we_d    = 1'b1;
               off_d   = DEV_PF_BASE_LIMIT_OFF;
               wdata_d = PF_CLOSED_VALUE;
               be_d    = 4'hF;
            end
         end
         S_DONE: begin
            state_d = S_IDLE;
            busy_d  = 1'b0;
            done_d  = 1'b1;
         end
         default: begin
            if (done_sync2_q && !req_q) begin
               req_d = 1'b1;
               we_d  = 1'b1;
               be_d  = 4'hF;
               case (state_q)
                  S_PF_BL: begin
                     state_d = S_PF_BU;
                     off_d   = DEV_PF_BASE_UPPER_OFF;
                     wdata_d = ALL_ZERO_VALUE;
                  end
                  S_PF_BU: begin
                     state_d = S_PF_LU;
                     off_d   = DEV_PF_LIMIT_UPPER_OFF;
                     wdata_d = ALL_ZERO_VALUE;
                  end
                  S_PF_LU: begin
                     state_d = S_IO_UP;
                     off_d   = DEV_IO_UPPER_OFF;
                     wdata_d = ALL_ZERO_VALUE;
                  end
                  S_IO_UP: begin
                     state_d = S_MEM_BL;
                     off_d   = DEV_MEM_BASE_LIMIT_OFF;
                     wdata_d = mem_need_q ? mem_win_q : MEM_CLOSED_VALUE;
                  end
                  S_MEM_BL: begin
                     state_d = S_IO_BL;
                     off_d   = DEV_IO_BASE_LIMIT_OFF;
                     wdata_d = {16'h0000, io_win_q[15:0]};
                     be_d    = 4'h3;
                  end
                  S_IO_BL: begin
                     state_d = S_PIN_RD;
                     we_d    = 1'b0;
                     off_d   = DEV_IRQ_BRCTL_OFF;
                     wdata_d = ALL_ZERO_VALUE;
                  end
                  S_PIN_RD: begin
                     irq_pin_d   = pin_field_w;
                     pin_valid_d = (pin_field_w != 8'h00);
                     state_d     = S_BRCTL;
                     off_d       = DEV_IRQ_BRCTL_OFF;
                     wdata_d     = {8'h00, brctl_low, 16'h0000};
                     be_d        = 4'h4;
                  end
                  default: begin
                     state_d = S_DONE;
                     req_d   = 1'b0;
                  end
               endcase
            end
         end
      endcase
   end

   // ****************************************
   // software read path
   // ****************************************
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (sw_rd_i) begin
         if (sw_addr_i == REG_CTRL_OFF) begin
            rdata_d = {29'h0, mem_need_q, b2b_q, 1'b0};
         end else if (sw_addr_i == REG_STATUS_OFF) begin
            rdata_d = {29'h0, pin_valid_q, done_q, busy_q};
         end else if (sw_addr_i == REG_IRQ_PIN_OFF) begin
            rdata_d = {24'h0, irq_pin_q};
         end else if (sw_addr_i == REG_MEM_WIN_OFF) begin
            rdata_d = mem_win_q;
         end else if (sw_addr_i == REG_IO_WIN_OFF) begin
            rdata_d = io_win_q;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_q     <= S_IDLE;
         busy_q      <= 1'b0;
         done_q      <= 1'b0;
         b2b_q       <= REG_CTRL_RESET[1];
         mem_need_q  <= REG_CTRL_RESET[2];
         mem_win_q   <= MEM_CLOSED_VALUE;
         io_win_q    <= REG_IO_WIN_RESET;
         irq_pin_q   <= 8'h00;
         pin_valid_q <= 1'b0;
         req_q       <= 1'b0;
         we_q        <= 1'b0;
         off_q       <= 8'h00;
         wdata_q     <= 32'h0000_0000;
         be_q        <= 4'h0;
         rdata_q     <= 32'h0000_0000;
      end else begin
         state_q     <= state_d;
         busy_q      <= busy_d;
         done_q      <= done_d;
         b2b_q       <= b2b_d;
         mem_need_q  <= mem_need_d;
         mem_win_q   <= mem_win_d;
         io_win_q    <= io_win_d;
         irq_pin_q   <= irq_pin_d;
         pin_valid_q <= pin_valid_d;
         req_q       <= req_d;
         we_q        <= we_d;
         off_q       <= off_d;
         wdata_q     <= wdata_d;
         be_q        <= be_d;
         rdata_q     <= rdata_d;
      end
   end

   assign sw_rdata_o  = rdata_q;
   assign cfg_req_o   = req_q;
   assign cfg_we_o    = we_q;
   assign cfg_off_o   = off_q;
   assign cfg_wdata_o = wdata_q;
   assign cfg_be_o    = be_q;

   // ****************************************
   // sequences
   // ****************************************
   sequence s_start_taken;
      (state_q == S_IDLE) && start_w;
   endsequence
   sequence s_pf_closed_req;
      cfg_req_o && cfg_we_o && (cfg_off_o == DEV_PF_BASE_LIMIT_OFF)
      && (cfg_wdata_o == PF_CLOSED_VALUE);
   endsequence
   sequence s_brctl_write;
      cfg_req_o && cfg_we_o && (cfg_off_o == DEV_IRQ_BRCTL_OFF);
   endsequence

   // ****************************************
   // checks
   // ****************************************
   a_rom_untouched: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      cfg_req_o |-> cfg_off_o != DEV_OPTION_ROM_OFF)
      else $error("option rom base accessed");
   a_upper_zero: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (cfg_req_o && (cfg_off_o == DEV_PF_BASE_UPPER_OFF || cfg_off_o == DEV_PF_LIMIT_UPPER_OFF))
      |-> cfg_we_o && cfg_wdata_o == 32'h0000_0000)
      else $error("upper prefetch half not zero");
   a_io_upper_zero: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (cfg_req_o && cfg_off_o == DEV_IO_UPPER_OFF) |-> cfg_wdata_o == 32'h0000_0000)
      else $error("upper io half not zero");
   a_brctl_fixed: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (cfg_req_o && cfg_we_o && cfg_off_o == DEV_IRQ_BRCTL_OFF)
      |-> cfg_wdata_o[BRCTL_POS_ISA] && !cfg_wdata_o[BRCTL_POS_VGA])
      else $error("isa or vga enable wrong");
   a_brctl_zeros: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (cfg_req_o && cfg_we_o && cfg_off_o == DEV_IRQ_BRCTL_OFF)
      |-> !cfg_wdata_o[BRCTL_POS_SYSERR] && !cfg_wdata_o[BRCTL_POS_PARITY]
          && !cfg_wdata_o[BRCTL_POS_MABORT] && !cfg_wdata_o[BRCTL_POS_SECRST])
      else $error("bridge control zero bits set");
   a_b2b_follow: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (cfg_req_o && cfg_we_o && cfg_off_o == DEV_IRQ_BRCTL_OFF)
      |-> cfg_wdata_o[BRCTL_POS_B2B] == b2b_q)
      else $error("b2b_capable_property enable mismatch");
   a_line_kept: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (cfg_req_o && cfg_we_o && cfg_off_o == DEV_IRQ_BRCTL_OFF) |-> cfg_be_o == 4'h4)
      else $error("interrupt line written");
   a_mem_closed: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (cfg_req_o && cfg_off_o == DEV_MEM_BASE_LIMIT_OFF && !mem_need_q)
      |-> cfg_wdata_o[15:0] > cfg_wdata_o[31:16])
      else $error("memory window not closed");
   a_pf_closed: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      s_start_taken |=> s_pf_closed_req)
      else $error("prefetch window not closed first");
   a_order_pf_base: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (cfg_req_o && cfg_off_o == DEV_PF_BASE_UPPER_OFF)
      |-> $past(cfg_off_o) == DEV_PF_BASE_LIMIT_OFF)
      else $error("prefetch base upper out of order");
   a_order_pf_limit: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (cfg_req_o && cfg_off_o == DEV_PF_LIMIT_UPPER_OFF)
      |-> $past(cfg_off_o) == DEV_PF_BASE_UPPER_OFF)
      else $error("prefetch limit upper out of order");
   a_order_io_upper: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (cfg_req_o && cfg_off_o == DEV_IO_UPPER_OFF)
      |-> $past(cfg_off_o) == DEV_PF_LIMIT_UPPER_OFF)
      else $error("io upper write out of order");
   a_order_mem: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (cfg_req_o && cfg_off_o == DEV_MEM_BASE_LIMIT_OFF)
      |-> $past(cfg_off_o) == DEV_IO_UPPER_OFF)
      else $error("memory window write out of order");
   a_pin_before_brctl: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      s_brctl_write
      |-> $past(cfg_off_o) == DEV_IRQ_BRCTL_OFF && !$past(cfg_we_o))
      else $error("bridge control written before pin read");
   a_pin_capture: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (state_q == S_PIN_RD && done_sync2_q && !req_q)
      |=> irq_pin_q == $past(pin_field_w))
      else $error("interrupt pin not recorded");
   a_pin_valid: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      pin_valid_q == (irq_pin_q != 8'h00))
      else $error("pin valid flag wrong");
   a_io_upper_lanes: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      (cfg_req_o && cfg_off_o == DEV_IO_UPPER_OFF) |-> cfg_we_o && cfg_be_o == 4'hF)
      else $error("io upper halves not both written");
   a_secrst_off: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      s_brctl_write |-> !cfg_wdata_o[BRCTL_POS_SECRST] && cfg_be_o[2])
      else $error("secondary reset control set");
   a_mabort_off: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      s_brctl_write |-> !cfg_wdata_o[BRCTL_POS_MABORT])
      else $error("master abort mode set");
   a_vga_off: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      s_brctl_write |-> !cfg_wdata_o[BRCTL_POS_VGA])
      else $error("vga enable set");
   a_b2b_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      busy_q |=> $stable(b2b_q))
      else $error("b2b_capable_property choice changed while busy");
   a_win_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      busy_q |=> $stable(mem_win_q) && $stable(mem_need_q))
      else $error("memory window changed while busy");
endmodule
`default_nettype wire

//--- include/pbcfg_pkg.sv
// pbcfg_pkg: constants for the bridge configuration host sequencer
// assumes a type 1 configuration header layout on the device side
package pbcfg_pkg;
   // ****************************************
   // device configuration dword offsets
   // ****************************************
   localparam logic [7:0]  DEV_IO_BASE_LIMIT_OFF  = 8'h1C;
   localparam logic [7:0]  DEV_MEM_BASE_LIMIT_OFF = 8'h20;
   localparam logic [7:0]  DEV_PF_BASE_LIMIT_OFF  = 8'h24;
   localparam logic [7:0]  DEV_PF_BASE_UPPER_OFF  = 8'h28;
   localparam logic [7:0]  DEV_PF_LIMIT_UPPER_OFF = 8'h2C;
   localparam logic [7:0]  DEV_IO_UPPER_OFF       = 8'h30;
   localparam logic [7:0]  DEV_OPTION_ROM_OFF     = 8'h38;
   localparam logic [7:0]  DEV_IRQ_BRCTL_OFF      = 8'h3C;
   // ****************************************
   // bridge control field positions
   // ****************************************
   localparam int          BRCTL_POS_PARITY       = 16;
   localparam int          BRCTL_POS_SYSERR       = 17;
   localparam int          BRCTL_POS_ISA          = 18;
   localparam int          BRCTL_POS_VGA          = 19;
   localparam int          BRCTL_POS_MABORT       = 21;
   localparam int          BRCTL_POS_SECRST       = 22;
   localparam int          BRCTL_POS_B2B          = 23;
   localparam int          IRQ_PIN_LSB            = 8;
   // ****************************************
   // controller register offsets
   // ****************************************
   localparam logic [3:0]  REG_CTRL_OFF           = 4'h0;
   localparam logic [3:0]  REG_STATUS_OFF         = 4'h1;
   localparam logic [3:0]  REG_IRQ_PIN_OFF        = 4'h2;
   localparam logic [3:0]  REG_MEM_WIN_OFF        = 4'h3;
   localparam logic [3:0]  REG_IO_WIN_OFF         = 4'h4;
   localparam logic [31:0] REG_CTRL_RESET         = 32'h0000_0000;
   localparam logic [31:0] REG_IO_WIN_RESET       = 32'h0000_00F0;
   // ****************************************
   // fixed write values
   // ****************************************
   localparam logic [31:0] MEM_CLOSED_VALUE       = 32'h0000_FFF0;
   localparam logic [31:0] PF_CLOSED_VALUE        = 32'h0000_FFF0;
   localparam logic [31:0] ALL_ZERO_VALUE         = 32'h0000_0000;
   localparam logic [7:0]  BRCTL_LOW_ISA_ONLY     = 8'h04;
   localparam logic [7:0]  BRCTL_LOW_ISA_B2B      = 8'h84;
endpackage

//--- testbench/pbcfg_dev_model.sv
// bridge configuration header model answering the host config port
// assumes one request pulse per access and holds of off/we/data/be
`timescale 1ns/1ps
`default_nettype none
module pbcfg_dev_model (
   // clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        rstn_i,
   // config port
   input  wire logic        cfg_req_i,
   input  wire logic        cfg_we_i,
   input  wire logic [7:0]  cfg_off_i,
   input  wire logic [31:0] cfg_wdata_i,
   input  wire logic [3:0]  cfg_be_i,
   output logic      [31:0] cfg_rdata_o,
   output logic             cfg_done_o,
   // test controls and decode view
   input  wire logic        slow_i,
   input  wire logic [7:0]  pin_i,
   output logic             sec_rstn_o,
   output logic             vga_fwd_o,
   output logic             isa_blk_o,
   output logic             mem_on_o
);
   logic [31:0] cfg_q [16];
   logic        busy_q;
   logic [3:0]  cnt_q;
   logic [3:0]  idx;
   assign idx = cfg_off_i[5:2];
   assign sec_rstn_o = rstn_i;
   assign vga_fwd_o = cfg_q[15][19];
   assign isa_blk_o = cfg_q[15][18];
   // window decodes whenever base is not above limit, unprogrammed reset contents included
   assign mem_on_o = cfg_q[8][15:4] <= cfg_q[8][31:20];
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int k = 0; k < 16; k++) cfg_q[k] <= 32'hA5A5_A5A5;
         busy_q <= 1'b0;
         cnt_q <= 4'h0;
         cfg_done_o <= 1'b0;
         cfg_rdata_o <= 32'h0000_0000;
      end else begin
         cfg_done_o <= 1'b0;
         cfg_rdata_o <= ~cfg_rdata_o;
         if (cfg_req_i) begin
            busy_q <= 1'b1;
            cnt_q <= slow_i ? 4'h6 : 4'h0;
         end else if (busy_q && cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
         end else if (busy_q) begin
            busy_q <= 1'b0;
            cfg_done_o <= 1'b1;
            if (cfg_we_i) begin
               for (int b = 0; b < 4; b++)
                  if (cfg_be_i[b] && idx != 4'hF || b == 2)
                     if (cfg_be_i[b]) cfg_q[idx][8*b +: 8] <= cfg_wdata_i[8*b +: 8];
            end else if (idx == 4'hF) begin
               cfg_rdata_o <= {cfg_q[15][31:16], pin_i, cfg_q[15][7:0]};
            end else begin
               // aborted read returns all ones with abort mode clear
               cfg_rdata_o <= cfg_q[15][21] ? cfg_q[idx] : 32'hFFFF_FFFF;
               if (!cfg_q[15][21] && idx < 4'h7) cfg_rdata_o <= 32'hFFFF_FFFF;
               else cfg_rdata_o <= cfg_q[idx];
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// self-checking bench for the bridge configuration host sequencer
// assumes the device model in pbcfg_dev_model on the config port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import pbcfg_pkg::*;
   logic        ref_clk_i, rstn_i, sw_wr_i, sw_rd_i, cfg_req_o, cfg_we_o, cfg_done_i;
   logic        slow, sec_rstn, vga_fwd, isa_blk, mem_on;
   logic [3:0]  sw_addr_i, cfg_be_o;
   logic [7:0]  cfg_off_o, pin;
   logic [31:0] sw_wdata_i, sw_rdata_o, cfg_wdata_o, cfg_rdata_i, d, mw, iw, me;
   int          errors, check_count, seed, i, n;
   pbcfg_host DUT (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .sw_addr_i(sw_addr_i),
      .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o),
      .cfg_req_o(cfg_req_o), .cfg_we_o(cfg_we_o), .cfg_off_o(cfg_off_o),
      .cfg_wdata_o(cfg_wdata_o), .cfg_be_o(cfg_be_o), .cfg_rdata_i(cfg_rdata_i),
      .cfg_done_i(cfg_done_i));
   pbcfg_dev_model part (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .cfg_req_i(cfg_req_o),
      .cfg_we_i(cfg_we_o), .cfg_off_i(cfg_off_o), .cfg_wdata_i(cfg_wdata_o),
      .cfg_be_i(cfg_be_o), .cfg_rdata_o(cfg_rdata_i), .cfg_done_o(cfg_done_i),
      .slow_i(slow), .pin_i(pin), .sec_rstn_o(sec_rstn), .vga_fwd_o(vga_fwd),
      .isa_blk_o(isa_blk), .mem_on_o(mem_on));
   // ****************************************
   // helpers
   // ****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic sw_write(input logic [3:0] a, input logic [31:0] v);
      @(posedge ref_clk_i);
      sw_addr_i <= a;
      sw_wdata_i <= v;
      sw_wr_i <= 1'b1;
      @(posedge ref_clk_i);
      sw_wr_i <= 1'b0;
   endtask
   task automatic sw_read(input logic [3:0] a, output logic [31:0] v);
      @(posedge ref_clk_i);
      sw_addr_i <= a;
      sw_rd_i <= 1'b1;
      @(posedge ref_clk_i);
      sw_rd_i <= 1'b0;
      #1 v = sw_rdata_o;
   endtask
   function automatic logic mem_open(input logic [31:0] v);
      return v[15:4] <= v[31:20];
   endfunction
   task automatic tally_and_finish;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ****************************************
   // clock, watchdog, sequence
   // ****************************************
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   initial begin
      #300000;
      errors++;
      tally_and_finish;
   end
   initial begin
      seed = 32'h14727b52;
      {rstn_i, sw_wr_i, sw_rd_i, slow, pin, sw_addr_i, sw_wdata_i} = '0;
      repeat (6) @(posedge ref_clk_i);
      check({31'h0, sec_rstn}, 32'h0);
      rstn_i <= 1'b1;
      sw_read(REG_MEM_WIN_OFF, d);
      check(d, MEM_CLOSED_VALUE);
      sw_read(REG_IO_WIN_OFF, d);
      check(d, REG_IO_WIN_RESET);
      sw_read(REG_CTRL_OFF, d);
      check(d, REG_CTRL_RESET);
      sw_read(4'hF, d);
      check(d, 32'h0000_0000);
      for (i = 0; i < 8; i++) begin
         mw = $random(seed);
         iw = $random(seed);
         pin = (i == 0) ? 8'h00 : 8'($random(seed));
         slow = i[2];
         if (i == 3) mw = 32'h0010_0000;
         sw_write(REG_MEM_WIN_OFF, mw);
         sw_write(REG_IO_WIN_OFF, iw);
         sw_write(REG_CTRL_OFF, {29'h0, i[1:0], 1'b1});
         sw_read(REG_STATUS_OFF, d);
         check({30'h0, d[1:0]}, 32'h1);
         sw_write(REG_MEM_WIN_OFF, ~mw);
         n = 0;
         do begin
            sw_read(REG_STATUS_OFF, d);
            n++;
         end while (d[1] !== 1'b1 && n < 300);
         check({29'h0, d[2:0]}, {29'h0, pin != 8'h00, 2'b10});
         sw_read(REG_IRQ_PIN_OFF, d);
         check(d, {24'h0, pin});
         sw_read(REG_MEM_WIN_OFF, d);
         check(d, mw);
         me = i[1] ? mw : MEM_CLOSED_VALUE;
         check(part.cfg_q[10], ALL_ZERO_VALUE);
         check(part.cfg_q[11], ALL_ZERO_VALUE);
         check(part.cfg_q[12], ALL_ZERO_VALUE);
         check(part.cfg_q[9], PF_CLOSED_VALUE);
         check(part.cfg_q[8], me);
         check({31'h0, mem_on}, {31'h0, mem_open(me)});
         check(part.cfg_q[7], {16'hA5A5, iw[15:0]});
         check(part.cfg_q[14], 32'hA5A5_A5A5);
         check(part.cfg_q[15], {8'hA5, i[0] ? 8'h84 : 8'h04, 16'hA5A5});
         check({30'h0, vga_fwd, isa_blk}, 32'h1);
      end
      // reset in the middle of a running sequence
      sw_write(REG_CTRL_OFF, 32'h0000_0007);
      repeat (4) @(posedge ref_clk_i);
      rstn_i <= 1'b0;
      @(posedge ref_clk_i);
      #1 check({31'h0, sec_rstn}, 32'h0);
      check({31'h0, cfg_req_o}, 32'h0);
      @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      sw_read(REG_STATUS_OFF, d);
      check(d, 32'h0);
      check({31'h0, sec_rstn}, 32'h1);
      sw_read(REG_MEM_WIN_OFF, d);
      check(d, MEM_CLOSED_VALUE);
      tally_and_finish;
   end
endmodule
`default_nettype wire
